// >>> design/ebsc_consts.svh
`ifndef EBSC_CONSTS_SVH
`define EBSC_CONSTS_SVH

// Register indices; the byte address is four times the index
`define EBSC_IDX_BUS_WIDTH   32'h00ff_fd84
`define EBSC_IDX_ACC_STATE   32'h00ff_fd86
`define EBSC_IDX_WAIT_A      32'h00ff_fd88
`define EBSC_IDX_WAIT_B      32'h00ff_fd8a
`define EBSC_IDX_IDLE        32'h00ff_fd90
`define EBSC_IDX_BYTE_ORDER  32'h00ff_fd95
`define EBSC_IDX_SRAM_MODE   32'h00ff_fd98
`define EBSC_IDX_DRAM_CTRL   32'h00ff_fda0
`define EBSC_IDX_DRAM_TIME   32'h00ff_fda2
`define EBSC_IDX_SDRAM_CTRL  32'h00ff_fda4
`define EBSC_IDX_REFR_CTRL   32'h00ff_fda6
`define EBSC_IDX_REFR_CNT    32'h00ff_fda8
`define EBSC_IDX_REFR_CONST  32'h00ff_fda9
`define EBSC_IDX_IRQ_STATUS  32'h00ff_fdb0
`define EBSC_IDX_IRQ_ENABLE  32'h00ff_fdb1
`define EBSC_IDX_IRQ_CLEAR   32'h00ff_fdb2

// Field positions
`define EBSC_WIDTH_HIGH_LSB  8
`define EBSC_WIDTH_LOW_LSB   0
`define EBSC_AREA_BIT_LSB    8
`define EBSC_AREA4_WAIT_LSB  0
`define EBSC_AREA2_WAIT_LSB  8
`define EBSC_IDLE_LSB        12
`define EBSC_DYN_SEL_BIT     15
`define EBSC_DYN_TYPE_BIT    14
`define EBSC_OE_CKE_BIT      11
`define EBSC_BURST_BIT       7
`define EBSC_PRECHG_LSB      12
`define EBSC_RAS_CAS_LSB     8
`define EBSC_MRS_BIT         15
`define EBSC_MATCH_FLAG_BIT  15
`define EBSC_REFR_CLK_LSB    8
`define EBSC_REFR_EN_BIT     7
`define EBSC_IRQ_MATCH_BIT   0
`define EBSC_IRQ_REFR_BIT    1

// Reset values
`define EBSC_RST_REG16       16'h0000
`define EBSC_RST_REG8        8'h00
`define EBSC_RST_IRQ         2'h0

`endif

// >>> design/ebsc_pkg.sv
package ebsc_pkg;

  typedef struct packed {
    logic width16;
    logic threeState;
    logic littleOrder;
    logic byteCtlIf;
  } ebsc_area_cfg_t;

  typedef struct packed {
    logic       dynMemArea2;
    logic       sdramType;
    logic       burstPage;
    logic [2:0] precharge;
    logic [1:0] rasCasWait;
    logic [2:0] casLatency;
    logic [2:0] area4Wait;
    logic [3:0] idleInsert;
  } ebsc_mem_cfg_t;

  typedef enum logic [2:0] {
    RF_IDLE = 3'b001,
    RF_REQ  = 3'b010,
    RF_WAIT = 3'b100
  } ebsc_refr_state_t;

endpackage : ebsc_pkg

// >>> design/ebsc_bus_ctrl.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "ebsc_consts.svh"
module ebsc_bus_ctrl
  import ebsc_pkg::*;
#(
  parameter int NAREA = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 memWrite,
  input  wire logic                 memByte,
  input  wire logic                 memArea2,
  input  wire logic                 memOeAssert,
  input  wire logic                 refreshAck,
  output ebsc_area_cfg_t [NAREA-1:0] areaCfg,
  output ebsc_mem_cfg_t             memCfg,
  output logic                      refreshReq,
  output logic                      modeRegWrite,
  output logic                      oeCkeOut,
  output logic                      oeCkeOen,
  output logic                      irq
);

  logic [15:0]      busWidth;
  logic [15:0]      accState;
  logic [15:0]      waitA;
  logic [15:0]      waitB;
  logic [15:0]      idleCtrl;
  logic [7:0]       byteOrder;
  logic [15:0]      sramMode;
  logic [15:0]      dramCtrl;
  logic [15:0]      dramTime;
  logic [15:0]      sdramCtrl;
  logic [15:0]      refrCtrl;
  logic [7:0]       refrCnt;
  logic [7:0]       refrConst;
  logic [1:0]       irqStatus;
  logic [1:0]       irqEnable;
  logic [11:0]      prescale;
  logic             refrTick;
  logic             cntMatch;
  logic             refrIssue;
  logic             setupPhase;
  logic             wrEn;
  logic             mapped;
  logic [31:0]      rdValue;
  ebsc_refr_state_t refrState;

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] idx);
    hit = (addr == {idx[29:0], 2'b00});
  endfunction : hit

  function automatic logic [11:0] divMask(input logic [2:0] sel);
    unique case (sel)
      3'b001:  divMask = 12'h001;
      3'b010:  divMask = 12'h007;
      3'b011:  divMask = 12'h01f;
      3'b100:  divMask = 12'h07f;
      3'b101:  divMask = 12'h1ff;
      3'b110:  divMask = 12'h7ff;
      3'b111:  divMask = 12'hfff;
      default: divMask = 12'h000;
    endcase
  endfunction : divMask

  // Zero-wait slave; read data is captured in the setup cycle
  assign setupPhase = psel & ~penable;
  assign wrEn       = psel & penable & pwrite & ~pslverr;
  assign pready     = 1'b1;

  always_comb begin
    mapped  = 1'b1;
    rdValue = 32'h0000_0000;
    if (hit(paddr, `EBSC_IDX_BUS_WIDTH)) begin
      rdValue[15:0] = busWidth;
    end else if (hit(paddr, `EBSC_IDX_ACC_STATE)) begin
      rdValue[15:0] = accState;
    end else if (hit(paddr, `EBSC_IDX_WAIT_A)) begin
      rdValue[15:0] = waitA;
    end else if (hit(paddr, `EBSC_IDX_WAIT_B)) begin
      rdValue[15:0] = waitB;
    end else if (hit(paddr, `EBSC_IDX_IDLE)) begin
      rdValue[15:0] = idleCtrl;
    end else if (hit(paddr, `EBSC_IDX_BYTE_ORDER)) begin
      rdValue[7:0] = byteOrder;
    end else if (hit(paddr, `EBSC_IDX_SRAM_MODE)) begin
      rdValue[15:0] = sramMode;
    end else if (hit(paddr, `EBSC_IDX_DRAM_CTRL)) begin
      rdValue[15:0] = dramCtrl;
    end else if (hit(paddr, `EBSC_IDX_DRAM_TIME)) begin
      rdValue[15:0] = dramTime;
    end else if (hit(paddr, `EBSC_IDX_SDRAM_CTRL)) begin
      rdValue[15:0] = sdramCtrl;
    end else if (hit(paddr, `EBSC_IDX_REFR_CTRL)) begin
      rdValue[15:0] = refrCtrl;
    end else if (hit(paddr, `EBSC_IDX_REFR_CNT)) begin
      rdValue[7:0] = refrCnt;
    end else if (hit(paddr, `EBSC_IDX_REFR_CONST)) begin
      rdValue[7:0] = refrConst;
    end else if (hit(paddr, `EBSC_IDX_IRQ_STATUS)) begin
      rdValue[1:0] = irqStatus;
    end else if (hit(paddr, `EBSC_IDX_IRQ_ENABLE)) begin
      rdValue[1:0] = irqEnable;
    end else if (hit(paddr, `EBSC_IDX_IRQ_CLEAR)) begin
      rdValue = 32'h0000_0000;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdValue;
      pslverr <= ~mapped;
    end
  end

  // Plain configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busWidth  <= `EBSC_RST_REG16;
      accState  <= `EBSC_RST_REG16;
      waitA     <= `EBSC_RST_REG16;
      waitB     <= `EBSC_RST_REG16;
      idleCtrl  <= `EBSC_RST_REG16;
      byteOrder <= `EBSC_RST_REG8;
      sramMode  <= `EBSC_RST_REG16;
      dramCtrl  <= `EBSC_RST_REG16;
      dramTime  <= `EBSC_RST_REG16;
      sdramCtrl <= `EBSC_RST_REG16;
      refrConst <= `EBSC_RST_REG8;
      irqEnable <= `EBSC_RST_IRQ;
    end else if (wrEn) begin
      if (hit(paddr, `EBSC_IDX_BUS_WIDTH))   busWidth  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_ACC_STATE))   accState  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_WAIT_A))      waitA     <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_WAIT_B))      waitB     <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_IDLE))        idleCtrl  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_BYTE_ORDER))  byteOrder <= pwdata[7:0];
      if (hit(paddr, `EBSC_IDX_SRAM_MODE))   sramMode  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_DRAM_CTRL))   dramCtrl  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_DRAM_TIME))   dramTime  <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_SDRAM_CTRL))  sdramCtrl <= pwdata[15:0];
      if (hit(paddr, `EBSC_IDX_REFR_CONST))  refrConst <= pwdata[7:0];
      if (hit(paddr, `EBSC_IDX_IRQ_ENABLE))  irqEnable <= pwdata[1:0];
    end
  end

  // Per-area decode
  for (genvar n = 0; n < NAREA; n++) begin : g_area
    assign areaCfg[n].width16     = ~busWidth[`EBSC_WIDTH_HIGH_LSB + n] & busWidth[`EBSC_WIDTH_LOW_LSB + n];
    assign areaCfg[n].threeState  = accState[`EBSC_AREA_BIT_LSB + n];
    assign areaCfg[n].littleOrder = byteOrder[n];
    assign areaCfg[n].byteCtlIf   = sramMode[`EBSC_AREA_BIT_LSB + n];
  end

  assign memCfg.dynMemArea2 = dramCtrl[`EBSC_DYN_SEL_BIT];
  assign memCfg.sdramType   = dramCtrl[`EBSC_DYN_SEL_BIT] & dramCtrl[`EBSC_DYN_TYPE_BIT];
  assign memCfg.burstPage   = dramCtrl[`EBSC_DYN_SEL_BIT] & dramCtrl[`EBSC_BURST_BIT];
  assign memCfg.precharge   = {1'b0, dramTime[`EBSC_PRECHG_LSB +: 2]} + 3'd1;
  assign memCfg.rasCasWait  = dramTime[`EBSC_RAS_CAS_LSB +: 2];
  assign memCfg.casLatency  = memCfg.sdramType ? {1'b0, waitB[`EBSC_AREA2_WAIT_LSB +: 2]} + 3'd1
                                               : waitB[`EBSC_AREA2_WAIT_LSB +: 3];
  assign memCfg.area4Wait   = waitA[`EBSC_AREA4_WAIT_LSB +: 3];
  assign memCfg.idleInsert  = idleCtrl[`EBSC_IDLE_LSB +: 4];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oeCkeOut <= 1'b0;
      oeCkeOen <= 1'b1;
    end else begin
      oeCkeOen <= ~dramCtrl[`EBSC_OE_CKE_BIT];
      oeCkeOut <= memCfg.sdramType ? 1'b1 : ~memOeAssert;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      modeRegWrite <= 1'b0;
    end else begin
      modeRegWrite <= sdramCtrl[`EBSC_MRS_BIT] & memCfg.sdramType & memArea2 & memWrite & memByte;
    end
  end

  // prescaler; one counter serves all seven rates
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prescale <= 12'h000;
    end else begin
      prescale <= prescale + 12'h001;
    end
  end

  assign refrTick = (refrCtrl[`EBSC_REFR_CLK_LSB +: 3] != 3'b000)
                  && ((prescale & divMask(refrCtrl[`EBSC_REFR_CLK_LSB +: 3]))
                      == divMask(refrCtrl[`EBSC_REFR_CLK_LSB +: 3]));
  assign cntMatch = (refrCnt == refrConst);

  // clear on match; a software write loses to the match
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refrCnt <= `EBSC_RST_REG8;
    end else if (cntMatch) begin
      refrCnt <= 8'h00;
    end else if (wrEn && hit(paddr, `EBSC_IDX_REFR_CNT)) begin
      refrCnt <= pwdata[7:0];
    end else if (refrTick) begin
      refrCnt <= refrCnt + 8'h01;
    end
  end

  // match flag, set wins over clear-by-zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refrCtrl <= `EBSC_RST_REG16;
    end else begin
      if (wrEn && hit(paddr, `EBSC_IDX_REFR_CTRL)) begin
        refrCtrl[14:0] <= pwdata[14:0];
        if (!pwdata[`EBSC_MATCH_FLAG_BIT]) begin
          refrCtrl[`EBSC_MATCH_FLAG_BIT] <= 1'b0;
        end
      end
      if (cntMatch) begin
        refrCtrl[`EBSC_MATCH_FLAG_BIT] <= 1'b1;
      end
    end
  end

  assign refrIssue = cntMatch & refrCtrl[`EBSC_REFR_EN_BIT];

  // Request held until the memory sequencer accepts it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refrState <= RF_IDLE;
    end else begin
      unique case (refrState)
        RF_IDLE: if (refrIssue) refrState <= RF_REQ;
        RF_REQ:  if (refreshAck) refrState <= RF_WAIT;
        RF_WAIT: if (!refreshAck) refrState <= RF_IDLE;
        default: refrState <= RF_IDLE;
      endcase
    end
  end
  assign refreshReq = (refrState == RF_REQ);

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= `EBSC_RST_IRQ;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wrEn && hit(paddr, `EBSC_IDX_IRQ_CLEAR) && pwdata[b]) begin
          irqStatus[b] <= 1'b0;
        end
      end
      if (cntMatch) irqStatus[`EBSC_IRQ_MATCH_BIT] <= 1'b1;
      if (refrIssue) irqStatus[`EBSC_IRQ_REFR_BIT] <= 1'b1;
    end
  end
  assign irq = |(irqStatus & irqEnable);

  property p_width16;
    @(posedge mclk) disable iff (!nrst)
      areaCfg[4].width16 == (!busWidth[12] && busWidth[4]);
  endproperty
  a_width16: assert property (p_width16) else $error("area 4 width decode wrong");

  property p_three;
    @(posedge mclk) disable iff (!nrst) wrEn && hit(paddr, `EBSC_IDX_ACC_STATE) |=> areaCfg[4].threeState == $past(pwdata[12]);
  endproperty
  a_three: assert property (p_three) else $error("state select not taken");

  property p_wait4;
    @(posedge mclk) disable iff (!nrst) waitA[2:0] == 3'b111 |-> memCfg.area4Wait == 3'd7;
  endproperty
  a_wait4: assert property (p_wait4) else $error("area 4 wait wrong");

  property p_cas;
    @(posedge mclk) disable iff (!nrst) memCfg.sdramType && waitB[9:8] == 2'b01 |-> memCfg.casLatency == 3'd2;
  endproperty
  a_cas: assert property (p_cas) else $error("CAS latency wrong");

  property p_prechg;
    @(posedge mclk) disable iff (!nrst) dramTime[13:12] == 2'b00 |-> memCfg.precharge == 3'd1;
  endproperty
  a_prechg: assert property (p_prechg) else $error("precharge count wrong");

  property p_mrs;
    @(posedge mclk) disable iff (!nrst) modeRegWrite |-> $past(memByte && memWrite && sdramCtrl[15]);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode write without byte write");

  property p_match;
    @(posedge mclk) disable iff (!nrst) cntMatch |=> refrCnt == 8'h00 && refrCtrl[15];
  endproperty
  a_match: assert property (p_match) else $error("match did not clear and flag");

  property p_norefr;
    @(posedge mclk) disable iff (!nrst) refrState == RF_IDLE && !refrCtrl[7] |=> refrState == RF_IDLE;
  endproperty
  a_norefr: assert property (p_norefr) else $error("refresh while disabled");

  property p_stop;
    @(posedge mclk) disable iff (!nrst)
      refrCtrl[10:8] == 3'b000 && !cntMatch && !wrEn |=> refrCnt == $past(refrCnt);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran without clock");

  property p_div8;
    @(posedge mclk) disable iff (!nrst) refrCtrl[10:8] == 3'b010 && refrTick |=> !refrTick [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide-by-8 spacing wrong");

endmodule : ebsc_bus_ctrl

// >>> bench/ebsc_mem_model.sv
`timescale 1ns/10ps
module ebsc_mem_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       refreshReq,
  input  wire logic       modeRegWrite,
  input  wire logic [3:0] ackDelay,
  output logic            memWrite,
  output logic            memByte,
  output logic            memArea2,
  output logic            memOeAssert,
  output logic            refreshAck
);
  int waitCnt;
  int refreshCount;
  int modeCount;

  initial begin
    memWrite = 1'b0;
    memByte = 1'b0;
    memArea2 = 1'b0;
    memOeAssert = 1'b0;
  end

  // refresh taken after a set delay
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      refreshAck <= 1'b0;
      waitCnt <= 0;
      refreshCount <= 0;
      modeCount <= 0;
    end else begin
      if (modeRegWrite === 1'b1) begin
        modeCount <= modeCount + 1;
      end
      // Ack held until the request drops, never earlier
      if (refreshAck) begin
        refreshAck <= refreshReq;
      end else if (refreshReq === 1'b1) begin
        if (waitCnt >= ackDelay) begin
          refreshAck <= 1'b1;
          waitCnt <= 0;
          refreshCount <= refreshCount + 1;
        end else begin
          waitCnt <= waitCnt + 1;
        end
      end
    end
  end

  // one memory cycle, reads ask for OE
  task automatic cycle(input logic wr, input logic bytes, input logic area2);
    @(posedge mclk);
    memWrite <= wr;
    memByte <= bytes;
    memArea2 <= area2;
    memOeAssert <= ~wr;
    @(posedge mclk);
    memWrite <= 1'b0;
    memByte <= 1'b0;
    memArea2 <= 1'b0;
    memOeAssert <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : cycle
endmodule : ebsc_mem_model

// >>> bench/test_ext_bus_area_sdram_ctrl.sv
`timescale 1ns/10ps
`include "ebsc_consts.svh"
module test_ext_bus_area_sdram_ctrl
  import ebsc_pkg::*;
;
  logic                 mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [31:0]          paddr, pwdata, prdata, rd;
  logic                 memWrite, memByte, memArea2, memOeAssert, refreshAck;
  ebsc_area_cfg_t [7:0] areaCfg;
  ebsc_mem_cfg_t        memCfg;
  logic                 refreshReq, modeRegWrite, oeCkeOut, oeCkeOen, irq, rerr;
  logic [3:0]           ackDelay;
  int                   mismatches, totalChecks, c0;
  logic [31:0]          regIdx [13] = '{`EBSC_IDX_BUS_WIDTH, `EBSC_IDX_ACC_STATE, `EBSC_IDX_WAIT_A,
    `EBSC_IDX_WAIT_B, `EBSC_IDX_IDLE, `EBSC_IDX_BYTE_ORDER, `EBSC_IDX_SRAM_MODE, `EBSC_IDX_DRAM_CTRL,
    `EBSC_IDX_DRAM_TIME, `EBSC_IDX_SDRAM_CTRL, `EBSC_IDX_REFR_CNT, `EBSC_IDX_REFR_CONST, `EBSC_IDX_IRQ_ENABLE};

  ebsc_bus_ctrl #(.NAREA(8)) ebsc_bus_ctrl_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .memWrite(memWrite), .memByte(memByte), .memArea2(memArea2), .memOeAssert(memOeAssert),
    .refreshAck(refreshAck), .areaCfg(areaCfg), .memCfg(memCfg), .refreshReq(refreshReq),
    .modeRegWrite(modeRegWrite), .oeCkeOut(oeCkeOut), .oeCkeOen(oeCkeOen), .irq(irq));
  ebsc_mem_model ebsc_mem_model_i (.mclk(mclk), .nrst(nrst), .refreshReq(refreshReq),
    .modeRegWrite(modeRegWrite), .ackDelay(ackDelay), .memWrite(memWrite), .memByte(memByte),
    .memArea2(memArea2), .memOeAssert(memOeAssert), .refreshAck(refreshAck));

  always #20 mclk = ~mclk;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Waits on pready itself; the slave latency is never assumed
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= idx << 2;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask : apb

  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rdchk(input string name, input logic [31:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(name, exp, rd);
  endtask : rdchk

  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    #(40 * 6000);
    mismatches++;
    results();
  end

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    ackDelay = 4'h0;
    mismatches = 0;
    totalChecks = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    foreach (regIdx[i]) rdchk("reset value", regIdx[i], 32'h0000_0000);
    apb(1'b0, 32'h0000_0040, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
    chk("unmapped data", 32'h0000_0000, rd);
    wr(`EBSC_IDX_BUS_WIDTH, 32'h0000_0414);
    chk("area4 width", 32'h0000_0001, areaCfg[4].width16);
    chk("area2 width", 32'h0000_0000, areaCfg[2].width16);
    wr(`EBSC_IDX_ACC_STATE, 32'h0000_1000);
    chk("area4 states", 32'h0000_0001, areaCfg[4].threeState);
    chk("area2 states", 32'h0000_0000, areaCfg[2].threeState);
    wr(`EBSC_IDX_WAIT_A, 32'h0000_0007);
    chk("area4 wait", 32'h0000_0007, memCfg.area4Wait);
    chk("idle none", 32'h0000_0000, memCfg.idleInsert);
    wr(`EBSC_IDX_IDLE, 32'h0000_3000);
    chk("idle three", 32'h0000_0003, memCfg.idleInsert);
    wr(`EBSC_IDX_BYTE_ORDER, 32'h0000_0010);
    chk("area4 order", 32'h0000_0001, areaCfg[4].littleOrder);
    chk("area2 order", 32'h0000_0000, areaCfg[2].littleOrder);
    wr(`EBSC_IDX_SRAM_MODE, 32'h0000_1000);
    chk("area4 bytectl", 32'h0000_0001, areaCfg[4].byteCtlIf);
    chk("area2 bytectl", 32'h0000_0000, areaCfg[2].byteCtlIf);
    wr(`EBSC_IDX_DRAM_TIME, 32'h0000_3100);
    chk("precharge code3", 32'h0000_0004, memCfg.precharge);
    chk("ras cas wait", 32'h0000_0001, memCfg.rasCasWait);
    wr(`EBSC_IDX_DRAM_TIME, 32'h0000_0000);
    chk("precharge code0", 32'h0000_0001, memCfg.precharge);
    chk("ras cas none", 32'h0000_0000, memCfg.rasCasWait);
    wr(`EBSC_IDX_WAIT_B, 32'h0000_0500);
    wr(`EBSC_IDX_DRAM_CTRL, 32'h0000_8880);
    // Pin enable is registered, one edge behind the write
    @(negedge mclk);
    chk("dyn select", 32'h0000_0001, memCfg.dynMemArea2);
    chk("edo type", 32'h0000_0000, memCfg.sdramType);
    chk("raw wait", 32'h0000_0005, memCfg.casLatency);
    chk("burst", 32'h0000_0001, memCfg.burstPage);
    chk("oe driven", 32'h0000_0000, oeCkeOen);
    chk("oe idle", 32'h0000_0001, oeCkeOut);
    fork
      ebsc_mem_model_i.cycle(1'b0, 1'b0, 1'b0);
      begin
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("oe asserted", 32'h0000_0000, oeCkeOut);
      end
    join
    wr(`EBSC_IDX_DRAM_CTRL, 32'h0000_C880);
    chk("sdram type", 32'h0000_0001, memCfg.sdramType);
    chk("cas latency", 32'h0000_0002, memCfg.casLatency);
    chk("cke high", 32'h0000_0001, oeCkeOut);
    wr(`EBSC_IDX_DRAM_CTRL, 32'h0000_C000);
    @(negedge mclk);
    chk("pin released", 32'h0000_0001, oeCkeOen);
    chk("no burst", 32'h0000_0000, memCfg.burstPage);
    wr(`EBSC_IDX_SDRAM_CTRL, 32'h0000_8000);
    ebsc_mem_model_i.cycle(1'b1, 1'b1, 1'b1);
    chk("mode write", 32'h0000_0001, ebsc_mem_model_i.modeCount);
    ebsc_mem_model_i.cycle(1'b1, 1'b0, 1'b1);
    ebsc_mem_model_i.cycle(1'b1, 1'b1, 1'b0);
    ebsc_mem_model_i.cycle(1'b0, 1'b1, 1'b1);
    chk("mode qualifiers", 32'h0000_0001, ebsc_mem_model_i.modeCount);
    wr(`EBSC_IDX_SDRAM_CTRL, 32'h0000_0000);
    ebsc_mem_model_i.cycle(1'b1, 1'b1, 1'b1);
    chk("mode ended", 32'h0000_0001, ebsc_mem_model_i.modeCount);
    wr(`EBSC_IDX_REFR_CONST, 32'h0000_0030);
    wr(`EBSC_IDX_IRQ_CLEAR, 32'h0000_0003);
    wr(`EBSC_IDX_REFR_CTRL, 32'h0000_0000);
    rdchk("flag cleared", `EBSC_IDX_REFR_CTRL, 32'h0000_0000);
    rdchk("status cleared", `EBSC_IDX_IRQ_STATUS, 32'h0000_0000);
    wr(`EBSC_IDX_REFR_CNT, 32'h0000_0030);
    rdchk("match flag", `EBSC_IDX_REFR_CTRL, 32'h0000_8000);
    rdchk("count cleared", `EBSC_IDX_REFR_CNT, 32'h0000_0000);
    chk("irq masked", 32'h0000_0000, irq);
    chk("no refresh off", 32'h0000_0000, ebsc_mem_model_i.refreshCount);
    wr(`EBSC_IDX_IRQ_ENABLE, 32'h0000_0001);
    chk("irq raised", 32'h0000_0001, irq);
    wr(`EBSC_IDX_IRQ_STATUS, 32'h0000_0000);
    rdchk("status read only", `EBSC_IDX_IRQ_STATUS, 32'h0000_0001);
    wr(`EBSC_IDX_IRQ_CLEAR, 32'h0000_0001);
    chk("irq cleared", 32'h0000_0000, irq);
    rdchk("clear reads zero", `EBSC_IDX_IRQ_CLEAR, 32'h0000_0000);
    wr(`EBSC_IDX_REFR_CONST, 32'h0000_00FF);
    wr(`EBSC_IDX_REFR_CTRL, 32'h0000_0200);
    wr(`EBSC_IDX_REFR_CNT, 32'h0000_0000);
    repeat (80) @(posedge mclk);
    apb(1'b0, `EBSC_IDX_REFR_CNT, 32'h0000_0000);
    chk("divide by 8", 32'h0000_0001, {31'h0, rd >= 9 && rd <= 11});
    wr(`EBSC_IDX_REFR_CTRL, 32'h0000_0000);
    apb(1'b0, `EBSC_IDX_REFR_CNT, 32'h0000_0000);
    c0 = rd;
    repeat (40) @(posedge mclk);
    rdchk("count stopped", `EBSC_IDX_REFR_CNT, c0);
    wr(`EBSC_IDX_REFR_CNT, 32'h0000_0000);
    wr(`EBSC_IDX_REFR_CONST, 32'h0000_0004);
    wr(`EBSC_IDX_REFR_CTRL, 32'h0000_0180);
    repeat (100) @(posedge mclk);
    chk("refresh issued", 32'h0000_0001, {31'h0, ebsc_mem_model_i.refreshCount > 0});
    apb(1'b0, `EBSC_IDX_REFR_CNT, 32'h0000_0000);
    chk("count bounded", 32'h0000_0001, {31'h0, rd <= 4});
    apb(1'b0, `EBSC_IDX_IRQ_STATUS, 32'h0000_0000);
    chk("refresh event", 32'h0000_0001, rd[1]);
    // Slow partner: matches during a pending refresh are dropped
    ackDelay <= 4'hF;
    c0 = ebsc_mem_model_i.refreshCount;
    repeat (100) @(posedge mclk);
    c0 = ebsc_mem_model_i.refreshCount - c0;
    chk("slow refresh", 32'h0000_0001, {31'h0, c0 >= 1 && c0 <= 7});
    wr(`EBSC_IDX_REFR_CTRL, 32'h0000_0100);
    repeat (30) @(posedge mclk);
    chk("request idle", 32'h0000_0000, {31'h0, refreshReq});
    c0 = ebsc_mem_model_i.refreshCount;
    repeat (100) @(negedge mclk);
    chk("refresh disabled", c0, ebsc_mem_model_i.refreshCount);
    results();
  end
endmodule : test_ext_bus_area_sdram_ctrl
